// ==== design/pg_ldo_map.vh ====
// Register map, field positions, reset values and timing counts
`ifndef PG_LDO_MAP_VH
`define PG_LDO_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL_PIN_MASK   8'hAC
`define OFS_AUX_REG_CTRL    8'hAE
`define OFS_RAIL_GOOD_LOW   8'hB0

// ****************************************
// Reset values
// ****************************************
`define RST_CTRL_PIN_MASK   8'hFF
`define RST_AUX_REG_CTRL    8'h7D
`define RST_RAIL_GOOD_LOW   8'h00

// ****************************************
// Mask register fields
// ****************************************
`define MSK_OUT1_IN3        7
`define MSK_OUT1_IN6        6
`define MSK_OUT4_IN3        5
`define MSK_OUT4_IN6        4
`define MSK_OUT2_IN3        3
`define MSK_OUT2_IN6        2
`define MSK_OUT3_IN3        1
`define MSK_OUT3_IN6        0

// ****************************************
// Regulator control fields
// ****************************************
`define DISCHG_HI           7
`define DISCHG_LO           6
`define EOFF_CFG_BIT        5
`define VCODE_HI            4
`define VCODE_LO            1
`define EN_BIT              0
`define DISCHG_NONE         2'h0
`define DISCHG_100          2'h1
`define DISCHG_200          2'h2
`define DISCHG_500          2'h3

// ****************************************
// Emergency-off durations
// ****************************************
`define CLK_MHZ             125
`define EOFF_MS_SEL0        1
`define EOFF_MS_SEL1        5
`define EOFF_MS_SEL2        10
`define EOFF_MS_SEL3        100
`define CYC_PER_MS          (`CLK_MHZ * 1000)

`endif

// ==== design/pg_tree.v ====
// One power-good output tree: AND of unmasked sources
`timescale 1ns/1ns
module pg_tree #(
  parameter N = 2
) (
  input  wire         clk,      // System clock
  input  wire         srst,     // Sync reset
  input  wire [N-1:0] src_good, // Source good levels
  input  wire [N-1:0] src_mask, // 1 excludes a source
  input  wire         base_good,// Rail part of the tree
  output reg          good_q    // Registered tree result
);
  always @(posedge clk)
  begin
    if (srst)
      good_q <= 1'b0;
    else
      good_q <= base_good & (&(src_good | src_mask));
  end
endmodule

// ==== design/pg_ldo_regs.v ====
// Power-good control-pin mask, aux regulator control and rail status
//
// Summary of operation
// - Mask bits 7,6 drop input three / six from first output tree.
// - Mask bits 5,4 drop input three / six from fourth output tree.
// - Mask bits 3,2 drop input three / six from second output tree.
// - Mask bits 1,0 drop input three / six from third output tree.
// - Mask register at 0xAC, read/write, resets to all ones.
// - Discharge bits 7:6 pick none, 100, 200, 500 ohm; reset 1.
// - Config bit 5 low: regulator off for set time on emergency.
// - Config bit 5 high: regulator follows enable bit 0 only.
// - Voltage code bits 4:1, reset 0xE.
// - Regulator control at 0xAE, read/write, resets to 0x7D.
// - Status bit reads 1 when rail in regulation; read-only.
// - Status bit 7 second regulator, bit 6 bank A load switch.
// - Status bits 5..0 report switchers six down to one.
// - Status register at 0xB0, reads zero after reset.
`timescale 1ns/1ns
`include "pg_ldo_map.vh"
module pg_ldo_regs #(
  parameter EOFF_SEL = 2'h0 // Factory duration select
) (
  input  wire       clk,            // System clock
  input  wire       srst,           // Sync reset, active high
  input  wire       wr_en,          // Register write strobe
  input  wire       rd_en,          // Register read strobe
  input  wire [7:0] addr,           // Register offset
  input  wire [7:0] wdata,          // Write data
  output reg  [7:0] rdata_q,        // Read data
  output reg        rvalid_q,       // Read data valid pulse
  input  wire       control_input_three, // Pin, async
  input  wire       control_input_six,   // Pin, async
  input  wire [3:0] rail_tree_good, // Rail part of each tree
  input  wire [7:0] rail_good_raw,  // Rail detector levels, async
  input  wire       emergency_off,  // Emergency shutdown level
  output wire       first_pg_output,  // Tree 1 good
  output wire       second_pg_output, // Tree 2 good
  output wire       third_pg_output,  // Tree 3 good
  output wire       fourth_pg_output, // Tree 4 good
  output reg        reg_on_q,       // Regulator switched on
  output reg  [1:0] dischg_q,       // Discharge select
  output reg  [3:0] vcode_q         // Target voltage code
);
  // ****************************************
  // Synchronisers
  // ****************************************
  reg  [9:0] sync1_q;
  reg  [9:0] sync2_q;
  reg  [7:0] mask_q;
  reg  [7:0] ctrl_q;
  reg  [7:0] status_q;
  reg        eoff_d1_q;
  reg [26:0] eoff_cnt_q;

  always @(posedge clk)
  begin
    if (srst)
    begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end
    else
    begin
      sync1_q <= {emergency_off, control_input_six, rail_good_raw};
      sync2_q <= sync1_q;
    end
  end

  wire in6_s  = sync2_q[8];
  wire eoff_s = sync2_q[9];
  reg  in3_s_q;
  reg  in3_m_q;
  always @(posedge clk)
  begin
    if (srst)
    begin
      in3_m_q <= 1'b0;
      in3_s_q <= 1'b0;
    end
    else
    begin
      in3_m_q <= control_input_three;
      in3_s_q <= in3_m_q;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Reset copies of the control fields follow the register reset
  localparam [7:0] CTRL_RST = `RST_AUX_REG_CTRL;

  // Shared write decode for both writable registers
  function wr_hit;
    input       en;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_hit = en && a == ofs;
    end
  endfunction

  always @(posedge clk)
  begin
    if (srst)
    begin
      mask_q   <= `RST_CTRL_PIN_MASK;
      ctrl_q   <= `RST_AUX_REG_CTRL;
      status_q <= `RST_RAIL_GOOD_LOW;
    end
    else
    begin
      status_q <= sync2_q[7:0];
      if (wr_hit(wr_en, addr, `OFS_CTRL_PIN_MASK))
        mask_q <= wdata;
      if (wr_hit(wr_en, addr, `OFS_AUX_REG_CTRL))
        ctrl_q <= wdata;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= rd_en;
      // Unmapped offsets read as zero
      case (addr)
        `OFS_CTRL_PIN_MASK: rdata_q <= mask_q;
        `OFS_AUX_REG_CTRL:  rdata_q <= ctrl_q;
        `OFS_RAIL_GOOD_LOW: rdata_q <= status_q;
        default:            rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Power-good trees
  // ****************************************
  wire [7:0] tree_mask = {mask_q[`MSK_OUT1_IN3], mask_q[`MSK_OUT1_IN6],
                          mask_q[`MSK_OUT2_IN3], mask_q[`MSK_OUT2_IN6],
                          mask_q[`MSK_OUT3_IN3], mask_q[`MSK_OUT3_IN6],
                          mask_q[`MSK_OUT4_IN3], mask_q[`MSK_OUT4_IN6]};
  wire [3:0] tree_out;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : trees
      pg_tree #(.N(2)) u_tree (
        .clk       (clk),
        .srst      (srst),
        .src_good  ({in3_s_q, in6_s}),
        .src_mask  (tree_mask[7-2*g -: 2]),
        .base_good (rail_tree_good[g]),
        .good_q    (tree_out[g])
      );
    end
  endgenerate
  assign first_pg_output  = tree_out[0];
  assign second_pg_output = tree_out[1];
  assign third_pg_output  = tree_out[2];
  assign fourth_pg_output = tree_out[3];

  // ****************************************
  // Regulator control
  // ****************************************
  function [26:0] eoff_cycles;
    input [1:0]  sel;
    reg   [31:0] cyc;
    begin
      case (sel)
        2'h0:    cyc = `EOFF_MS_SEL0 * `CYC_PER_MS;
        2'h1:    cyc = `EOFF_MS_SEL1 * `CYC_PER_MS;
        2'h2:    cyc = `EOFF_MS_SEL2 * `CYC_PER_MS;
        default: cyc = `EOFF_MS_SEL3 * `CYC_PER_MS;
      endcase
      // Longest window fits well inside the counter
      eoff_cycles = cyc[26:0];
    end
  endfunction

  // Output drops in the cycle the window starts, not one later
  wire eoff_rise = eoff_s && !eoff_d1_q && !ctrl_q[`EOFF_CFG_BIT];

  // Off window restarts on each rising edge of emergency shutdown while config bit 5 is low
  always @(posedge clk)
  begin
    if (srst)
    begin
      eoff_d1_q  <= 1'b0;
      eoff_cnt_q <= 27'h0000000;
    end
    else
    begin
      eoff_d1_q <= eoff_s;
      if (eoff_rise)
        eoff_cnt_q <= eoff_cycles(EOFF_SEL);
      else if (eoff_cnt_q != 27'h0000000)
        eoff_cnt_q <= eoff_cnt_q - 27'h0000001;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      reg_on_q <= 1'b0;
      dischg_q <= CTRL_RST[`DISCHG_HI:`DISCHG_LO];
      vcode_q  <= CTRL_RST[`VCODE_HI:`VCODE_LO];
    end
    else
    begin
      dischg_q <= ctrl_q[`DISCHG_HI:`DISCHG_LO];
      vcode_q  <= ctrl_q[`VCODE_HI:`VCODE_LO];
      if (ctrl_q[`EOFF_CFG_BIT])
        reg_on_q <= ctrl_q[`EN_BIT];
      else
        reg_on_q <= ctrl_q[`EN_BIT] && !eoff_rise &&
                    eoff_cnt_q == 27'h0000000;
    end
  end
endmodule

// ==== tb/rail_env.sv ====
// Pin and rail detector levels outside the bank
`timescale 1ns/1ns
module rail_env (
  input  wire       clk,  // System clock
  input  wire [9:0] lvl,  // Wanted levels
  output reg  [9:0] lv_q  // Pin three, pin six, rails
);
  // Moves away from the sampling edge, like a real pin
  initial lv_q = 10'h000;
  always @(negedge clk)
    lv_q <= lvl;
endmodule

// ==== tb/pg_ldo_regs_properties.sv ====
// Port checker for the power-good and regulator bank
`timescale 1ns/1ns
module pg_ldo_chk (
  input wire logic       clk,             // Clock
  input wire logic       srst,            // Reset
  input wire logic       wr_en,           // Write
  input wire logic       rd_en,           // Read
  input wire logic [7:0] addr,            // Offset
  input wire logic [7:0] wdata,           // Data in
  input wire logic [7:0] rdata_q,         // Data out
  input wire logic       rvalid_q,        // Valid
  input wire logic [3:0] rail_tree_good,  // Tree rails
  input wire logic [7:0] rail_good_raw,   // Rails
  input wire logic       first_pg_output, // Tree 1
  input wire logic       reg_on_q,        // On
  input wire logic [1:0] dischg_q,        // Discharge
  input wire logic [3:0] vcode_q          // Voltage
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] wd_q;
  wire ctl_wr = wr_en && addr == 8'hAE;
  wire hole = !(addr inside {8'hAC, 8'hAE, 8'hB0});
  always @(posedge clk)
    if (ctl_wr)
      wd_q <= wdata;
  // Detector levels held long enough to reach the status copy
  sequence raw_steady;
    $stable(rail_good_raw) [*4];
  endsequence
  rd_valid_a: assert property (rd_en |=> rvalid_q)
    else $error("read gave no valid");
  no_rd_a: assert property (!rd_en |=> !rvalid_q)
    else $error("valid without read");
  hole_read_a: assert property (rd_en && hole |=> !rdata_q)
    else $error("unmapped read not zero");
  status_read_a: assert property (raw_steady ##0 (rd_en &&
    addr == 8'hB0) |=> rdata_q == $past(rail_good_raw))
    else $error("status differs from rails");
  dischg_wr_a: assert property (ctl_wr |-> ##[1:2]
    dischg_q == wd_q[7:6]) else $error("discharge copy wrong");
  vcode_wr_a: assert property (ctl_wr |-> ##[1:2]
    vcode_q == wd_q[4:1]) else $error("voltage copy wrong");
  en_off_a: assert property (ctl_wr && wdata[5] && !wdata[0]
    |-> ##[1:3] !reg_on_q) else $error("regulator stayed on");
  tree_low_a: assert property (!rail_tree_good[0]
    |=> !first_pg_output) else $error("tree good with bad rail");
endmodule
bind pg_ldo_regs pg_ldo_chk i_chk (.clk, .srst, .wr_en, .rd_en, .addr,
  .wdata, .rdata_q, .rvalid_q, .rail_tree_good, .rail_good_raw,
  .first_pg_output, .reg_on_q, .dischg_q, .vcode_q);

// ==== tb/pg_ldo_regs_tb_top.sv ====
// Self-checking bench for the power-good and regulator bank
`timescale 1ns/1ns
module pg_ldo_regs_tb_top;
  logic       clk = 0, srst = 1, wr_en = 0, rd_en = 0, emergency_off = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_q;
  logic [9:0] lvl = 10'h000, lv_q;
  logic [3:0] rail_tree_good = 4'hF, vcode_q;
  wire  [3:0] pg;
  logic       rvalid_q, reg_on_q;
  logic [1:0] dischg_q;
  int         err_count = 0, num_checks = 0;
  always #4 clk = ~clk;
  rail_env i_env (.clk(clk), .lvl(lvl), .lv_q(lv_q));
  pg_ldo_regs i_dut (.clk(clk), .srst(srst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .control_input_three(lv_q[9]), .control_input_six(lv_q[8]),
    .rail_tree_good(rail_tree_good), .rail_good_raw(lv_q[7:0]),
    .emergency_off(emergency_off), .first_pg_output(pg[0]),
    .second_pg_output(pg[1]), .third_pg_output(pg[2]),
    .fourth_pg_output(pg[3]), .reg_on_q(reg_on_q), .dischg_q(dischg_q),
    .vcode_q(vcode_q));
  // ****
  // Access tasks
  // ****
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    rd_en = 0;
    chk({7'h00, rvalid_q}, 8'h01);
    chk(rdata_q, exp);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Outputs {4,3,2,1} when only the tree of mask bit b sees a low pin
  function automatic logic [7:0] tree_exp(input int b);
    case (b / 2)
      3: return 8'h0E;
      2: return 8'h07;
      1: return 8'h0D;
      default: return 8'h0B;
    endcase
  endfunction
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 0;
    emergency_off = 1;
    repeat (6) @(negedge clk);
    chk({dischg_q, vcode_q, reg_on_q, 1'b0}, 8'h7A);
    emergency_off = 0;
    rd(8'hAC, 8'hFF);
    rd(8'hAE, 8'h7D);
    rd(8'hB0, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hAE, {i[1:0], 6'h2B});
      rd(8'hAE, {i[1:0], 6'h2B});
      chk({dischg_q, vcode_q, 2'h0}, {i[1:0], 6'h14});
    end
    wr(8'hAE, 8'h2A);
    repeat (3) @(negedge clk);
    chk({7'h00, reg_on_q}, 8'h00);
    wr(8'hAE, 8'h5D);
    repeat (3) @(negedge clk);
    chk({7'h00, reg_on_q}, 8'h01);
    emergency_off = 1;
    repeat (8) @(negedge clk);
    chk({7'h00, reg_on_q}, 8'h00);
    repeat (1000) @(negedge clk);
    chk({7'h00, reg_on_q}, 8'h00);
    emergency_off = 0;
    wr(8'hAE, 8'h7D);
    repeat (3) @(negedge clk);
    chk({7'h00, reg_on_q}, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      lvl = k ? 10'h05A : 10'h0A5;
      repeat (5) @(negedge clk);
      wr(8'hB0, 8'h00);
      rd(8'hB0, lvl[7:0]);
    end
    rd(8'hAD, 8'h00);
    rail_tree_good = 4'hB;
    lvl = 10'h000;
    repeat (4) @(negedge clk);
    chk({4'h0, pg}, 8'h0B);
    rail_tree_good = 4'hE;
    repeat (4) @(negedge clk);
    chk({4'h0, pg}, 8'h0E);
    rail_tree_good = 4'hF;
    for (int b = 0; b < 8; b++)
    begin
      wr(8'hAC, ~(8'h01 << b));
      lvl = b[0] ? 10'h100 : 10'h200;
      repeat (4) @(negedge clk);
      chk({4'h0, pg}, tree_exp(b));
      rd(8'hAC, ~(8'h01 << b));
    end
    wrap_up();
  end
endmodule
